/* File: rtl/save_ctrl_pkg.sv */
// Purpose: Shared constants and types for the compacted state save controller
// Assumes: APB with 32-bit data, one word per register
// Notes:   64-bit values sit in pairs of words, low word first
package save_ctrl_pkg;

   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned NUM_PAIRS = 7;

   // Writable 64-bit pairs: byte offset = 8 * pair index (+4 for high word)
   localparam logic [2:0] PAIR_INS_MASK = 3'h0;
   localparam logic [2:0] PAIR_USER_EN  = 3'h1;
   localparam logic [2:0] PAIR_SUPV_EN  = 3'h2;
   localparam logic [2:0] PAIR_IN_USE   = 3'h3;
   localparam logic [2:0] PAIR_MODIFIED = 3'h4;
   localparam logic [2:0] PAIR_AREA     = 3'h5;
   localparam logic [2:0] PAIR_RST_COMP = 3'h6;

   localparam logic [7:0] OFF_SIMD_CSR  = 8'h38;
   localparam logic [7:0] OFF_CTRL      = 8'h3C;
   localparam logic [7:0] OFF_CMD       = 8'h40;
   localparam logic [7:0] OFF_STATUS    = 8'h44;
   localparam logic [7:0] OFF_STATEV_LO = 8'h48;
   localparam logic [7:0] OFF_STATEV_HI = 8'h4C;
   localparam logic [7:0] OFF_COMPV_LO  = 8'h50;
   localparam logic [7:0] OFF_COMPV_HI  = 8'h54;
   localparam logic [7:0] OFF_STORE_LO  = 8'h58;
   localparam logic [7:0] OFF_STORE_HI  = 8'h5C;

   // Control register fields
   localparam int unsigned CTRL_OS_EN    = 0;
   localparam int unsigned CTRL_TASK_SW  = 3;
   localparam int unsigned CTRL_ALIGN_EN = 4;
   localparam int unsigned CTRL_ALIGN_CK = 5;
   localparam int unsigned CTRL_NONROOT  = 6;
   localparam int unsigned CTRL_LEVEL_LSB  = 8;
   localparam int unsigned CTRL_ALIGN_PREF = 16;

   // Command register fields
   localparam int unsigned CMD_COMPACT  = 0;
   localparam int unsigned CMD_SUPV     = 1;
   localparam int unsigned CMD_RESTORE  = 2;

   localparam logic [31:0] SIMD_INIT     = 32'h0000_1F80;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] SIMD_RESET    = 32'h0000_1F80;
   localparam int unsigned AREA_ALIGN_W  = 6;
   localparam logic [1:0]  LEVEL_KERNEL  = 2'h0;
   localparam logic [1:0]  LEVEL_USER    = 2'h3;

   typedef enum logic [2:0] {
      FLT_NONE = 3'h0,
      FLT_INV_OPCODE  = 3'h1,
      FLT_DEV_UNAVAIL = 3'h2,
      FLT_GEN_PROT    = 3'h3,
      FLT_ALIGN_CHK   = 3'h4
   } fault_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CHECK = 2'h1,
      ST_WRITE = 2'h2
   } state_type;

   typedef struct packed {
      logic [1:0]  level;
      logic        nonroot;
      logic [63:0] area;
   } ctx_type;

   typedef struct packed {
      logic        valid;
      ctx_type     ctx;
      logic [63:0] comp;
   } record_type;

endpackage : save_ctrl_pkg

/* File: rtl/compacted_state_save_control.sv */
// Purpose: Fault checks, header vectors and store selection for compacted saves
// Assumes: APB master per AMBA, single clock pclk at 25 MHz
// Notes:   Results are exposed as registers and ports; memory writes are external
// Functional notes
// - Ordinary save mask is user enable AND instruction mask.
// - Save enable clear gives invalid-opcode fault, no save, both variants.
// - Task-switched flag set gives device-unavailable fault instead of saving.
// - Area not 64-byte aligned gives general-protection fault, no save.
// - Alignment mask, level 3, check flag set may give alignment fault instead.
// - Supervisor save with privilege above 0 gives general-protection fault.
// - Supervisor mask is instruction mask AND (user OR supervisor enable).
// - State vector bit is 0 where unrequested, else in-use flag.
// - Requested SIMD component with non-reset control word forces state bit 1.
// - Compaction vector gets bit 63 set and mask bits 62:0.
// - Only state and compaction vectors of the header are written.
// - Ordinary save never reads the old state vector first.
// - Components 0-1 go legacy region, 2-62 compacted extended region.
// - Components not in use are skipped even if requested.
// - Dirty SIMD control word forces storing all of component 1.
// - Mask bit 2 never decides storing the SIMD control word.
// - Ordinary save never uses the modified optimization.
// - Supervisor save uses modified skip only on full restore record match.
// - Under modified optimization, unmodified components are skipped.
// - Each restore records level, non-root flag, address, compaction vector.
`timescale 1ns/1ps
module compacted_state_save_control (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [save_ctrl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                     pwdata,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   output logic                                 header_write,
   output logic      [63:0]                     store_mask,
   output logic      [2:0]                      fault_code
);

   logic [63:0]               pair_q [save_ctrl_pkg::NUM_PAIRS];
   logic [31:0]               simd_q;
   logic [31:0]               ctrl_q;
   save_ctrl_pkg::state_type  state_q;
   save_ctrl_pkg::fault_type  fault_q;
   save_ctrl_pkg::fault_type  fault_d;
   save_ctrl_pkg::record_type rec_q;
   save_ctrl_pkg::ctx_type    ctx;
   logic                      sup_q;
   logic [63:0]               req_mask_d;
   logic [63:0]               req_mask_q;
   logic                      dirty_d;
   logic                      dirty_q;
   logic                      modopt_d;
   logic                      modopt_q;
   logic [63:0]               statev_q;
   logic [63:0]               compv_q;
   logic [63:0]               store_q;
   logic                      hdr_wr_q;
   logic                      done_q;
   logic [31:0]               prdata_q;
   logic [31:0]               rd_d;
   logic                      hit_d;
   logic                      wr_acc;
   logic                      start_ok;
   logic                      os_en;
   logic                      task_sw;
   logic                      misalign;

   assign ctx         = '{level:   ctrl_q[save_ctrl_pkg::CTRL_LEVEL_LSB +: 2],
                          nonroot: ctrl_q[save_ctrl_pkg::CTRL_NONROOT],
                          area:    pair_q[save_ctrl_pkg::PAIR_AREA]};
   assign os_en       = ctrl_q[save_ctrl_pkg::CTRL_OS_EN];
   assign task_sw     = ctrl_q[save_ctrl_pkg::CTRL_TASK_SW];
   assign misalign    = |ctx.area[save_ctrl_pkg::AREA_ALIGN_W-1:0];

   // Zero wait states: read data is captured in the setup phase
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_d;
   assign prdata  = prdata_q;
   assign wr_acc  = psel & penable & pwrite & hit_d;
   assign start_ok = wr_acc && (paddr == save_ctrl_pkg::OFF_CMD) && (state_q == save_ctrl_pkg::ST_IDLE);

   assign header_write = hdr_wr_q;
   assign store_mask   = store_q;
   assign fault_code   = fault_q;

   // Read decode; high pair words hold the upper 32 bits
   always_comb begin
      rd_d  = 32'h0000_0000;
      hit_d = 1'b1;
      if (paddr < save_ctrl_pkg::OFF_SIMD_CSR) begin
         rd_d = paddr[2] ? pair_q[paddr[5:3]][63:32] : pair_q[paddr[5:3]][31:0];
      end else begin
         unique case (paddr)
            save_ctrl_pkg::OFF_SIMD_CSR:  rd_d = simd_q;
            save_ctrl_pkg::OFF_CTRL:      rd_d = ctrl_q;
            save_ctrl_pkg::OFF_CMD:       rd_d = 32'h0000_0000;
            save_ctrl_pkg::OFF_STATUS:    rd_d = {25'h000_0000, store_q[1], modopt_q, fault_q, done_q,
                                                  state_q != save_ctrl_pkg::ST_IDLE};
            save_ctrl_pkg::OFF_STATEV_LO: rd_d = statev_q[31:0];
            save_ctrl_pkg::OFF_STATEV_HI: rd_d = statev_q[63:32];
            save_ctrl_pkg::OFF_COMPV_LO:  rd_d = compv_q[31:0];
            save_ctrl_pkg::OFF_COMPV_HI:  rd_d = compv_q[63:32];
            save_ctrl_pkg::OFF_STORE_LO:  rd_d = store_q[31:0];
            save_ctrl_pkg::OFF_STORE_HI:  rd_d = store_q[63:32];
            default:                      hit_d = 1'b0;
         endcase
      end
      if (paddr[1:0] != 2'h0) begin
         hit_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= rd_d;
      end
   end

   // Software-written configuration; pairs take either word independently
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < save_ctrl_pkg::NUM_PAIRS; i++) begin
            pair_q[i] <= 64'h0000_0000_0000_0000;
         end
         simd_q <= save_ctrl_pkg::SIMD_RESET;
         ctrl_q <= save_ctrl_pkg::CTRL_RESET;
      end else if (wr_acc) begin
         if (paddr < save_ctrl_pkg::OFF_SIMD_CSR) begin
            if (paddr[2]) begin
               pair_q[paddr[5:3]][63:32] <= pwdata;
            end else begin
               pair_q[paddr[5:3]][31:0] <= pwdata;
            end
         end else if (paddr == save_ctrl_pkg::OFF_SIMD_CSR) begin
            simd_q <= pwdata;
         end else if (paddr == save_ctrl_pkg::OFF_CTRL) begin
            ctrl_q <= pwdata;
         end
      end
   end

   // A restore command snapshots the context for later supervisor saves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_q <= '0;
      end else if (start_ok && pwdata[save_ctrl_pkg::CMD_RESTORE]) begin
         rec_q.valid <= 1'b1;
         rec_q.ctx   <= ctx;
         rec_q.comp  <= pair_q[save_ctrl_pkg::PAIR_RST_COMP];
      end
   end

   // Mask formation, fault priority and optimizations
   always_comb begin
      if (sup_q) begin
         req_mask_d = pair_q[save_ctrl_pkg::PAIR_INS_MASK]
                      & (pair_q[save_ctrl_pkg::PAIR_USER_EN] | pair_q[save_ctrl_pkg::PAIR_SUPV_EN]);
      end else begin
         req_mask_d = pair_q[save_ctrl_pkg::PAIR_INS_MASK] & pair_q[save_ctrl_pkg::PAIR_USER_EN];
      end
      // Only mask bit 1 gates the control word, bit 2 plays no part
      dirty_d = req_mask_d[1] && (simd_q != save_ctrl_pkg::SIMD_INIT);
      fault_d = save_ctrl_pkg::FLT_NONE;
      if (!os_en) begin
         fault_d = save_ctrl_pkg::FLT_INV_OPCODE;
      end else if (task_sw) begin
         fault_d = save_ctrl_pkg::FLT_DEV_UNAVAIL;
      end else if (sup_q && ctx.level != save_ctrl_pkg::LEVEL_KERNEL) begin
         fault_d = save_ctrl_pkg::FLT_GEN_PROT;
      end else if (misalign) begin
         if (ctrl_q[save_ctrl_pkg::CTRL_ALIGN_PREF] && ctrl_q[save_ctrl_pkg::CTRL_ALIGN_EN]
             && ctrl_q[save_ctrl_pkg::CTRL_ALIGN_CK] && ctx.level == save_ctrl_pkg::LEVEL_USER) begin
            fault_d = save_ctrl_pkg::FLT_ALIGN_CHK;
         end else begin
            fault_d = save_ctrl_pkg::FLT_GEN_PROT;
         end
      end
      // Ordinary save never qualifies; supervisor needs an exact record match
      modopt_d = sup_q && rec_q.valid && (rec_q.ctx == ctx) && rec_q.comp[63]
                 && (rec_q.comp[62:0] == req_mask_d[62:0]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= save_ctrl_pkg::ST_IDLE;
         sup_q   <= 1'b0;
      end else begin
         unique case (state_q)
            save_ctrl_pkg::ST_IDLE: begin
               if (start_ok && (pwdata[save_ctrl_pkg::CMD_COMPACT] || pwdata[save_ctrl_pkg::CMD_SUPV])) begin
                  state_q <= save_ctrl_pkg::ST_CHECK;
                  sup_q   <= pwdata[save_ctrl_pkg::CMD_SUPV];
               end
            end
            save_ctrl_pkg::ST_CHECK: state_q <= save_ctrl_pkg::ST_WRITE;
            save_ctrl_pkg::ST_WRITE: state_q <= save_ctrl_pkg::ST_IDLE;
            default:                 state_q <= save_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // Faults settle a full cycle before anything is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q  <= save_ctrl_pkg::FLT_NONE;
         req_mask_q <= 64'h0000_0000_0000_0000;
         dirty_q  <= 1'b0;
         modopt_q <= 1'b0;
      end else if (state_q == save_ctrl_pkg::ST_CHECK) begin
         fault_q  <= fault_d;
         req_mask_q <= req_mask_d;
         dirty_q  <= dirty_d;
         modopt_q <= modopt_d;
      end
   end

   // Header and store vectors; nothing is read back from the save area
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         statev_q <= 64'h0000_0000_0000_0000;
         compv_q  <= 64'h0000_0000_0000_0000;
         store_q  <= 64'h0000_0000_0000_0000;
         hdr_wr_q <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         hdr_wr_q <= 1'b0;
         if (start_ok) begin
            done_q <= 1'b0;
         end
         if (state_q == save_ctrl_pkg::ST_WRITE) begin
            done_q <= 1'b1;
            if (fault_q == save_ctrl_pkg::FLT_NONE) begin
               hdr_wr_q    <= 1'b1;
               statev_q    <= req_mask_q & pair_q[save_ctrl_pkg::PAIR_IN_USE];
               statev_q[1] <= (req_mask_q[1] & pair_q[save_ctrl_pkg::PAIR_IN_USE][1]) | dirty_q;
               compv_q     <= {1'b1, req_mask_q[62:0]};
               // Bits 1:0 land in the legacy region, 62:2 compacted; 63 is no component
               store_q     <= {1'b0, req_mask_q[62:0] & pair_q[save_ctrl_pkg::PAIR_IN_USE][62:0]
                               & (modopt_q ? pair_q[save_ctrl_pkg::PAIR_MODIFIED][62:0]
                                           : {63{1'b1}})};
               if (dirty_q) begin
                  store_q[1] <= 1'b1;
               end
            end
         end
      end
   end

   // Save accepted: command write while idle with either save bit
   sequence seq_save_start;
      start_ok && (pwdata[save_ctrl_pkg::CMD_COMPACT] || pwdata[save_ctrl_pkg::CMD_SUPV]);
   endsequence

   // Fixed walk; software polls busy, so its length is part of the contract
   sequence seq_save_walk;
      state_q == save_ctrl_pkg::ST_CHECK ##1 state_q == save_ctrl_pkg::ST_WRITE
      ##1 (state_q == save_ctrl_pkg::ST_IDLE && done_q);
   endsequence

   // Check cycle of a save that passes every fault test
   sequence seq_clean_check;
      state_q == save_ctrl_pkg::ST_CHECK && fault_d == save_ctrl_pkg::FLT_NONE;
   endsequence

   sequence seq_faulty_run;
      state_q == save_ctrl_pkg::ST_CHECK ##1
      (state_q == save_ctrl_pkg::ST_WRITE && fault_q != save_ctrl_pkg::FLT_NONE);
   endsequence

   AST_NO_WRITE_ON_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
      seq_faulty_run |=> !hdr_wr_q && $stable(statev_q) && $stable(store_q))
      else $error("Header written by a faulting save");

   AST_USER_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && !sup_q |=>
      req_mask_q == ($past(pair_q[save_ctrl_pkg::PAIR_INS_MASK]) & $past(pair_q[save_ctrl_pkg::PAIR_USER_EN])))
      else $error("Ordinary save mask wrong");

   AST_UD_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && !os_en |=> fault_q == save_ctrl_pkg::FLT_INV_OPCODE ##1 !hdr_wr_q)
      else $error("Missing invalid-opcode fault");

   AST_NM_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && os_en && task_sw |=> fault_q == save_ctrl_pkg::FLT_DEV_UNAVAIL)
      else $error("Missing device-unavailable fault");

   AST_ALIGN_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && os_en && !task_sw && misalign |=>
      fault_q inside {save_ctrl_pkg::FLT_GEN_PROT, save_ctrl_pkg::FLT_ALIGN_CHK})
      else $error("Misaligned area not faulted");

   AST_SUPV_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && sup_q && os_en && !task_sw
      && ctx.level != save_ctrl_pkg::LEVEL_KERNEL |=>
      fault_q == save_ctrl_pkg::FLT_GEN_PROT)
      else $error("Supervisor save above level 0 not faulted");

   AST_STATEV_SUBSET: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> (statev_q & ~req_mask_q) == 64'h0000_0000_0000_0000)
      else $error("State vector bit set outside the mask");

   AST_SIMD_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q && dirty_q |-> statev_q[1] && store_q[1])
      else $error("Dirty SIMD control word not forced");

   AST_COMPV: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> compv_q[63] && compv_q[62:0] == req_mask_q[62:0])
      else $error("Compaction vector wrong");

   AST_INIT_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> (store_q & ~statev_q) == 64'h0000_0000_0000_0000)
      else $error("Component stored while not in use");

   AST_NO_MODOPT_USER: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q && !sup_q |-> !modopt_q)
      else $error("Ordinary save used modified optimization");

   AST_SAVE_WALK: assert property (@(posedge pclk) disable iff (!presetn)
      seq_save_start |=> seq_save_walk)
      else $error("Save did not walk check, write, done");

   AST_SUPV_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && sup_q |=>
      req_mask_q == ($past(pair_q[save_ctrl_pkg::PAIR_INS_MASK])
                     & ($past(pair_q[save_ctrl_pkg::PAIR_USER_EN])
                        | $past(pair_q[save_ctrl_pkg::PAIR_SUPV_EN]))))
      else $error("Supervisor save mask wrong");

   AST_ALIGN_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && !(ctrl_q[save_ctrl_pkg::CTRL_ALIGN_EN]
      && ctrl_q[save_ctrl_pkg::CTRL_ALIGN_CK] && ctx.level == save_ctrl_pkg::LEVEL_USER) |=>
      fault_q != save_ctrl_pkg::FLT_ALIGN_CHK)
      else $error("Alignment fault without its conditions");

   AST_CLEAN_WRITES: assert property (@(posedge pclk) disable iff (!presetn)
      seq_clean_check |=> state_q == save_ctrl_pkg::ST_WRITE ##1 hdr_wr_q)
      else $error("Clean save wrote no header");

   AST_HDR_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |=> !hdr_wr_q)
      else $error("Header write longer than one cycle");

   AST_HDR_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> $past(state_q) == save_ctrl_pkg::ST_WRITE
      && $past(fault_q) == save_ctrl_pkg::FLT_NONE)
      else $error("Header written outside a clean write cycle");

   // Bit 1 is left out: a dirty control word may force it
   AST_STATEV_INUSE: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> (statev_q & 64'hFFFF_FFFF_FFFF_FFFD)
      == (req_mask_q & $past(pair_q[save_ctrl_pkg::PAIR_IN_USE]) & 64'hFFFF_FFFF_FFFF_FFFD))
      else $error("State vector differs from in-use flags");

   AST_STORE_TOP: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q |-> !store_q[63])
      else $error("Store requested for bit 63");

   // The dirty control word is the only store that may ignore the modified flags
   AST_MOD_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_wr_q && modopt_q |-> (store_q & ~$past(pair_q[save_ctrl_pkg::PAIR_MODIFIED])
      & ~{62'h0, dirty_q, 1'b0}) == 64'h0000_0000_0000_0000)
      else $error("Unmodified component stored");

   AST_MODOPT_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_WRITE && modopt_q |-> sup_q && rec_q.valid && rec_q.ctx == $past(ctx)
      && rec_q.comp[63] && rec_q.comp[62:0] == req_mask_q[62:0])
      else $error("Modified optimization without a matching record");

   // Snapshot is taken at the command edge, so later config writes cannot leak in
   AST_RECORD: assert property (@(posedge pclk) disable iff (!presetn)
      start_ok && pwdata[save_ctrl_pkg::CMD_RESTORE] |=> rec_q.valid && rec_q.ctx == $past(ctx)
      && rec_q.comp == $past(pair_q[save_ctrl_pkg::PAIR_RST_COMP]))
      else $error("Restore record not taken");

   AST_SIMD_BIT2: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == save_ctrl_pkg::ST_CHECK && !req_mask_d[1] |=> !dirty_q)
      else $error("Control word forced without mask bit 1");

endmodule : compacted_state_save_control

/* File: sim/save_area_model.sv */
// Purpose: Save area memory seen from the controller's result ports
// Assumes: header_write marks one completed header update with its store mask
// Notes:   Keeps the count of header updates and the last component store set
`timescale 1ns/1ps
module save_area_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        header_write,
   input  wire logic [63:0] store_mask,
   output int               header_count_q,
   output logic      [63:0] stored_mask_q
);
   // Only header updates land here, so a faulting save must leave both untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         header_count_q <= 0;
         stored_mask_q  <= '0;
      end else if (header_write) begin
         header_count_q <= header_count_q + 1;
         stored_mask_q  <= store_mask;
      end
   end
endmodule : save_area_model

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the compacted state save controller
// Assumes: Zero wait state APB slave, results valid once busy clears
// Notes:   Fault mix cycles every eight saves; saves 6-15 and 22-31 are supervisor
`timescale 1ns/1ps
module tb_top;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, rdat, ctrl, simd;
   logic        pready, pslverr, header_write, rerr, sup, modopt, f1;
   logic [63:0] store_mask, stored, ins, usr, supv, inuse, modf, area, mask, e_sv, e_cv, e_st, rarea, rcomp, v;
   logic [2:0]  fault_code, flt;
   logic [1:0]  rcpl;
   logic        rnr, rok;
   logic [31:0] seed = 32'h47F1EA96;
   int          hcount, e_hw;
   int          failures  = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   logic [31:0] ctab [8] = '{32'h0, 32'h9, 32'h301, 32'h1, 32'h10331, 32'h1, 32'h1, 32'h1};

   always #20 pclk = ~pclk;

   compacted_state_save_control compacted_state_save_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .header_write(header_write), .store_mask(store_mask), .fault_code(fault_code));
   save_area_model save_area_model_i (.pclk(pclk), .presetn(presetn), .header_write(header_write),
      .store_mask(store_mask), .header_count_q(hcount), .stored_mask_q(stored));

   function logic [31:0] nxt();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
      return seed;
   endfunction : nxt

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Idle edge at the end keeps psel from being driven twice in one time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr64(input logic [2:0] p, input logic [63:0] d);
      apb(1'b1, {2'h0, p, 3'h0}, d[31:0]);
      apb(1'b1, {2'h0, p, 3'h4}, d[63:32]);
   endtask : wr64

   task automatic rd64(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      v[31:0] = rdat;
      apb(1'b0, a + 8'h04, 32'h0);
      v[63:32] = rdat;
   endtask : rd64

   task automatic finish_test();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, save_ctrl_pkg::OFF_SIMD_CSR, 32'h0);
      chk(rdat, save_ctrl_pkg::SIMD_RESET);
      apb(1'b0, save_ctrl_pkg::OFF_CTRL, 32'h0);
      chk(rdat, save_ctrl_pkg::CTRL_RESET);
      apb(1'b0, 8'hFC, 32'h0);
      chk({rerr, rdat}, {1'b1, 32'h0});
      e_sv = '0; e_cv = '0; e_st = '0; e_hw = 0; rok = 1'b0;
      for (int i = 0; i < 32; i++) begin
         ins = {nxt(), nxt()}; usr = {nxt(), nxt()}; supv = {nxt(), nxt()};
         inuse = {nxt(), nxt()}; modf = {nxt(), nxt()};
         simd = nxt();
         simd = simd[0] ? save_ctrl_pkg::SIMD_INIT : {16'h0, simd[16:1]};
         ctrl = ctab[i % 8] | (nxt() & 32'h40);
         area = {nxt(), nxt() & 32'hFFFF_FFC0} | ((i % 8 == 4 || i % 8 == 5) ? 64'h8 : 64'h0);
         sup = (i / 8) % 2 == 1 || i % 8 >= 6;
         mask = sup ? ins & (usr | supv) : ins & usr;
         wr64(save_ctrl_pkg::PAIR_INS_MASK, ins); wr64(save_ctrl_pkg::PAIR_USER_EN, usr);
         wr64(save_ctrl_pkg::PAIR_SUPV_EN, supv); wr64(save_ctrl_pkg::PAIR_IN_USE, inuse);
         wr64(save_ctrl_pkg::PAIR_MODIFIED, modf); wr64(save_ctrl_pkg::PAIR_AREA, area);
         apb(1'b1, save_ctrl_pkg::OFF_SIMD_CSR, simd);
         apb(1'b1, save_ctrl_pkg::OFF_CTRL, ctrl);
         if (i % 8 >= 6) begin
            rcomp = {i % 8 == 6, mask[62:0]};
            wr64(save_ctrl_pkg::PAIR_RST_COMP, rcomp);
            apb(1'b1, save_ctrl_pkg::OFF_CMD, 32'h4);
            rok = 1'b1; rcpl = ctrl[9:8]; rnr = ctrl[6]; rarea = area;
         end
         if (!ctrl[0]) flt = 3'h1;
         else if (ctrl[3]) flt = 3'h2;
         else if (sup && ctrl[9:8] != 2'h0) flt = 3'h3;
         else if (area[5:0] != 6'h0) flt = (ctrl[4] && ctrl[5] && ctrl[9:8] == 2'h3 && ctrl[16]) ? 3'h4 : 3'h3;
         else flt = 3'h0;
         f1 = mask[1] && simd != save_ctrl_pkg::SIMD_INIT;
         modopt = sup && rok && rcpl == ctrl[9:8] && rnr == ctrl[6] && rarea == area && rcomp[63] &&
                  rcomp[62:0] == mask[62:0];
         if (flt == 3'h0) begin
            e_sv = (mask & inuse) | {62'h0, f1, 1'b0};
            e_cv = {1'b1, mask[62:0]};
            e_st = ((mask & inuse & (modopt ? modf : '1)) | {62'h0, f1, 1'b0}) & {1'b0, {63{1'b1}}};
            e_hw++;
         end
         apb(1'b1, save_ctrl_pkg::OFF_CMD, sup ? 32'h2 : 32'h1);
         for (int n = 0; n < 8; n++) begin
            apb(1'b0, save_ctrl_pkg::OFF_STATUS, 32'h0);
            if (rdat[0] === 1'b0) break;
         end
         chk(rdat[4:0], {flt, 2'b10});
         if (flt == 3'h0) chk(rdat[6:5], {e_st[1], modopt});
         chk(fault_code, flt);
         rd64(save_ctrl_pkg::OFF_STATEV_LO);
         chk(v, e_sv);
         rd64(save_ctrl_pkg::OFF_COMPV_LO);
         chk(v, e_cv);
         rd64(save_ctrl_pkg::OFF_STORE_LO);
         chk(v, e_st);
         chk(stored, e_st);
         chk(hcount, e_hw);
      end
      finish_test();
   end
endmodule : tb_top
